// ==== rtl/spc_pkg.sv ====
package spc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] SPC_OFF_DATA = 3'h0;
  localparam logic [2:0] SPC_OFF_STATUS = 3'h1;
  localparam logic [2:0] SPC_OFF_IRQLVL = 3'h3;
  localparam logic [2:0] SPC_OFF_ENABLE = 3'h4;
  localparam logic [2:0] SPC_OFF_FORMAT = 3'h5;
  localparam logic [2:0] SPC_OFF_BAUDL = 3'h6;
  localparam logic [2:0] SPC_OFF_BAUDH = 3'h7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] SPC_RST_ENABLE = 8'h00;
  localparam logic [7:0] SPC_RST_FORMAT = 8'h03;
  localparam logic [7:0] SPC_RST_BAUDL = 8'h00;
  localparam logic [7:0] SPC_RST_BAUDH = 8'h00;
  localparam logic [7:0] SPC_RST_IRQLVL = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SPC_EN_RX = 4;
  localparam int SPC_EN_TX = 3;
  localparam int SPC_EN_2X = 2;
  localparam int SPC_EN_MPC = 1;
  localparam int SPC_EN_B8 = 0;
  localparam int SPC_FMT_ORDER = 2;
  localparam int SPC_FMT_PHASE = 1;
  localparam int SPC_ST_TXDONE = 6;
  localparam int SPC_ST_EMPTY = 5;
  localparam int SPC_ST_FRAME_ERROR_FLAG = 4;
  localparam int SPC_ST_OVR = 3;
  localparam int SPC_ST_PARITY_ERROR_FLAG = 2;
  localparam int SPC_ST_RXB8 = 0;
  localparam int SPC_ST_RXDONE = 7;

  // ==========================================================
  // Timing counts
  localparam logic [4:0] SPC_DIV_NORMAL = 5'h10;
  localparam logic [4:0] SPC_DIV_DOUBLE = 5'h08;

  typedef enum logic [1:0] {
    SPC_MODE_ASYNC,
    SPC_MODE_SYNC,
    SPC_MODE_INFRARED,
    SPC_MODE_MSPI
  } spc_mode_t;

  typedef enum logic [1:0] {
    SPC_PAR_OFF,
    SPC_PAR_RSVD,
    SPC_PAR_EVEN,
    SPC_PAR_ODD
  } spc_par_t;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spc_req_t;

  // Decoded interrupt requests
  typedef struct packed {
    logic [1:0] tx_done_level;
    logic [1:0] empty_level;
    logic [1:0] rx_level;
  } spc_irq_t;

endpackage

// ==== rtl/spc_serial_port.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module spc_serial_port
  import spc_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire spc_req_t req, // Register bus request
  output logic [7:0] rdata, // Read data, cycle after strobe
  input wire logic rx_pin, // Receive pin
  output logic tx_out, // Transmit pin level
  output logic tx_oe, // Transmitter owns transmit pin
  output logic rx_owned, // Receiver owns receive pin
  output logic xck_out, // Transfer clock in master SPI
  output spc_irq_t irq // Interrupt requests with level
);

  // ==========================================================
  // Registers
  logic [7:0] enable_ctl;
  logic [7:0] format_ctl;
  logic [7:0] baud_lo;
  logic [7:0] baud_hi;
  logic [5:0] irq_lvl;
  logic wr_en, wr_fmt, wr_bl, wr_bh, wr_irq, wr_data, wr_stat;

  assign wr_en = req.wr && req.addr == SPC_OFF_ENABLE;
  assign wr_fmt = req.wr && req.addr == SPC_OFF_FORMAT;
  assign wr_bl = req.wr && req.addr == SPC_OFF_BAUDL;
  assign wr_bh = req.wr && req.addr == SPC_OFF_BAUDH;
  assign wr_irq = req.wr && req.addr == SPC_OFF_IRQLVL;
  assign wr_data = req.wr && req.addr == SPC_OFF_DATA;
  assign wr_stat = req.wr && req.addr == SPC_OFF_STATUS;

  // Configuration storage; reserved enable bits stay zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_ctl <= SPC_RST_ENABLE;
      format_ctl <= SPC_RST_FORMAT;
      baud_lo <= SPC_RST_BAUDL;
      baud_hi <= SPC_RST_BAUDH;
      irq_lvl <= SPC_RST_IRQLVL[5:0];
    end else begin
      if (wr_en) enable_ctl <= {3'h0, req.wdata[4:0]};
      if (wr_fmt) format_ctl <= req.wdata;
      if (wr_bl) baud_lo <= req.wdata;
      if (wr_bh) baud_hi <= req.wdata;
      if (wr_irq) irq_lvl <= req.wdata[5:0];
    end
  end

  spc_mode_t mode;
  spc_par_t par;
  logic [11:0] divider;
  logic signed [3:0] scale;
  assign mode = spc_mode_t'(format_ctl[7:6]);
  assign par = spc_par_t'(format_ctl[5:4]);
  assign divider = {baud_hi[3:0], baud_lo};
  assign scale = baud_hi[7:4];

  // Data bits per character; reserved codes fall back to 8
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  logic [3:0] nbits;
  logic mspi;
  assign mspi = mode == SPC_MODE_MSPI;
  assign nbits = mspi ? 4'h8 : char_bits(format_ctl[2:0]);

  // ==========================================================
  // Baud generator: prescaler then scale then divisor
  logic [11:0] pre_cnt;
  logic [4:0] sub_cnt;
  logic [6:0] scl_cnt;
  logic [4:0] divisor;
  logic [6:0] scl_top;
  logic bit_tick;
  logic async_mode;
  assign async_mode = mode == SPC_MODE_ASYNC || mode == SPC_MODE_INFRARED;
  // Synchronous modes run two prescaler steps per bit, ignoring double speed
  assign divisor = async_mode ? (enable_ctl[SPC_EN_2X] ? SPC_DIV_DOUBLE : SPC_DIV_NORMAL)
                              : 5'h02;
  // Negative scale is approximated by no scaling; -8 treated likewise
  assign scl_top = scale[3] ? 7'h00 : 7'((7'h01 << scale[2:0]) - 7'h01);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt <= 12'h000;
      sub_cnt <= 5'h00;
      scl_cnt <= 7'h00;
    end else if (wr_bl) begin
      pre_cnt <= 12'h000;
      sub_cnt <= 5'h00;
      scl_cnt <= 7'h00;
    end else if (pre_cnt < divider) begin
      pre_cnt <= pre_cnt + 12'h001;
    end else begin
      pre_cnt <= 12'h000;
      if (scl_cnt < scl_top) begin
        scl_cnt <= scl_cnt + 7'h01;
      end else begin
        scl_cnt <= 7'h00;
        sub_cnt <= (sub_cnt == divisor - 5'h01) ? 5'h00 : sub_cnt + 5'h01;
      end
    end
  end
  assign bit_tick = !wr_bl && pre_cnt >= divider && scl_cnt >= scl_top
                    && sub_cnt == divisor - 5'h01;

  // ==========================================================
  // Transmit buffer and shifter
  logic [8:0] tx_buf;
  logic tx_buf_full;
  logic [11:0] tx_shift;
  logic [3:0] tx_left;
  logic tx_busy;
  logic tx_done_flag, buffer_empty_flag;
  logic tx_active;
  logic tx_par;
  logic load_shift;
  logic tx_finish;
  logic [11:0] tx_frame;

  // Hold enable until everything queued has gone out
  assign tx_active = enable_ctl[SPC_EN_TX] || tx_busy || tx_buf_full;
  assign load_shift = tx_active && tx_buf_full && !tx_busy && bit_tick;
  assign tx_finish = tx_busy && bit_tick && tx_left == 4'h1;

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) p = p ^ d[i];
    end
    return p;
  endfunction

  // Bit-order reversal for msb-first master SPI
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) rev8[i] = d[7 - i];
  endfunction

  // Asynchronous frame image: start 0, data, optional parity, stop ones above
  assign tx_par = parity_of(tx_buf, nbits, par == SPC_PAR_ODD);
  always_comb begin
    tx_frame = 12'hfff << (nbits + 4'h1);
    tx_frame = tx_frame | (({3'h0, tx_buf} << 1) & ~tx_frame);
    if (par[1]) tx_frame[nbits + 4'h1] = tx_par;
  end

  // Buffer write is ignored while the buffer is still full
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf <= 9'h000;
      tx_buf_full <= 1'b0;
    end else begin
      if (wr_data && !tx_buf_full) begin
        tx_buf <= {enable_ctl[SPC_EN_B8], req.wdata};
        tx_buf_full <= 1'b1;
      end else if (load_shift) begin
        tx_buf_full <= 1'b0;
      end
    end
  end

  // Frame: start, data lsb first, parity, stop(s); shifted from bit 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
    end else if (load_shift) begin
      tx_busy <= 1'b1;
      if (mspi) begin
        tx_shift <= {4'hf, format_ctl[SPC_FMT_ORDER] ? tx_buf[7:0] : rev8(tx_buf[7:0])};
        tx_left <= 4'h8;
      end else begin
        tx_shift <= tx_frame;
        tx_left <= 4'(nbits + 4'h2 + {3'h0, par[1]} + {3'h0, format_ctl[3]});
      end
    end else if (tx_busy && bit_tick) begin
      tx_shift <= {1'b1, tx_shift[11:1]};
      tx_left <= tx_left - 4'h1;
      if (tx_left == 4'h1) tx_busy <= 1'b0;
    end
  end

  // Status flags; set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_done_flag <= 1'b0;
      buffer_empty_flag <= 1'b1;
    end else begin
      if (tx_finish && !tx_buf_full) tx_done_flag <= 1'b1;
      else if (wr_stat && req.wdata[SPC_ST_TXDONE]) tx_done_flag <= 1'b0;
      if (wr_data && !tx_buf_full) buffer_empty_flag <= 1'b0;
      else if (load_shift) buffer_empty_flag <= 1'b1;
    end
  end

  // Pin and clock outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
      rx_owned <= 1'b0;
      xck_out <= 1'b0;
    end else begin
      tx_out <= tx_busy ? tx_shift[0] : 1'b1;
      tx_oe <= tx_active;
      rx_owned <= enable_ctl[SPC_EN_RX];
      // Mid-bit clock edge; phase picks which half is high
      xck_out <= mspi && tx_busy && ((sub_cnt == 5'h0) ^ format_ctl[SPC_FMT_PHASE]);
    end
  end

  // ==========================================================
  // Receiver: 3-stage input, sample mid bit
  logic rx_s1, rx_s2, rx_s3, rx_lvl;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_lvl <= rx_s3;
    end
  end

  logic rx_on;
  logic rx_busy;
  logic [3:0] rx_idx;
  logic [8:0] rx_sh;
  logic rx_par_bit;
  logic [8:0] rx_data;
  logic rx_full, frame_error_flag, rx_overrun_flag, parity_error_flag;
  logic rx_mid;
  logic [3:0] rx_last;
  logic os_tick;
  logic [4:0] rx_os;
  assign rx_on = enable_ctl[SPC_EN_RX];
  // Own bit phase from the start edge; the shared bit tick has arbitrary phase
  assign os_tick = !wr_bl && pre_cnt >= divider && scl_cnt >= scl_top;
  assign rx_mid = rx_busy && os_tick
                  && rx_os == (rx_idx == 4'h0 ? (divisor >> 1) - 5'h01 : divisor - 5'h01);
  assign rx_last = 4'(nbits + {3'h0, par[1]} + 4'h1);

  // Receive shifter; bit index 0 is start, then data, parity, stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy <= 1'b0;
      rx_idx <= 4'h0;
      rx_sh <= 9'h000;
      rx_par_bit <= 1'b0;
      rx_os <= 5'h00;
    end else if (!rx_on) begin
      rx_busy <= 1'b0;
    end else if (!rx_busy) begin
      if (!rx_lvl) begin
        rx_busy <= 1'b1;
        rx_idx <= 4'h0;
        rx_sh <= 9'h000;
        rx_os <= 5'h00;
      end
    end else begin
      if (os_tick) rx_os <= rx_mid ? 5'h00 : rx_os + 5'h01;
      if (rx_mid) begin
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx >= 4'h1 && rx_idx <= nbits) rx_sh[rx_idx - 4'h1] <= rx_lvl;
        if (par[1] && rx_idx == nbits + 4'h1) rx_par_bit <= rx_lvl;
        if (rx_idx == rx_last) rx_busy <= 1'b0;
      end
    end
  end

  logic rx_end;
  logic rx_keep;
  assign rx_end = rx_on && rx_busy && rx_mid && rx_idx == rx_last;
  // Address frames carry a one in the ninth bit
  assign rx_keep = !enable_ctl[SPC_EN_MPC] || (nbits == 4'h9 && rx_sh[8]);

  // Receive buffer, single level; flushed when the receiver is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= 9'h000;
      rx_full <= 1'b0;
      frame_error_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else if (!rx_on) begin
      rx_full <= 1'b0;
      frame_error_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else if (rx_end && rx_keep) begin
      rx_full <= 1'b1;
      if (rx_full) begin
        rx_overrun_flag <= 1'b1;
      end else begin
        rx_data <= mspi && !format_ctl[SPC_FMT_ORDER] ? {1'b0, rev8(rx_sh[7:0])} : rx_sh;
        frame_error_flag <= !mspi && !rx_lvl;
        parity_error_flag <= par[1] && !mspi
          && (parity_of(rx_sh, nbits, par == SPC_PAR_ODD) != rx_par_bit);
      end
    end else if (req.rd && req.addr == SPC_OFF_DATA) begin
      rx_full <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        SPC_OFF_DATA: rdata <= rx_data[7:0];
        SPC_OFF_STATUS: rdata <= {rx_full, tx_done_flag, buffer_empty_flag, frame_error_flag,
                                  rx_overrun_flag, parity_error_flag, 1'b0, rx_data[8]};
        SPC_OFF_IRQLVL: rdata <= {2'h0, irq_lvl};
        SPC_OFF_ENABLE: rdata <= enable_ctl;
        SPC_OFF_FORMAT: rdata <= format_ctl;
        SPC_OFF_BAUDL: rdata <= baud_lo;
        SPC_OFF_BAUDH: rdata <= baud_hi;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Interrupt requests carry the programmed level while the flag is up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= '0;
    end else begin
      irq.tx_done_level <= tx_done_flag ? irq_lvl[3:2] : 2'h0;
      irq.empty_level <= buffer_empty_flag ? irq_lvl[1:0] : 2'h0;
      irq.rx_level <= rx_full ? irq_lvl[5:4] : 2'h0;
    end
  end

  // ==========================================================
  // Assertions
  property p_empty_clear;
    @(posedge clk) disable iff (!arst_n)
    (wr_data && buffer_empty_flag) |=> !buffer_empty_flag;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty flag not cleared");

  property p_tx_irq;
    @(posedge clk) disable iff (!arst_n)
    (tx_done_flag && irq_lvl[3:2] != 2'h0) |=> irq.tx_done_level == $past(irq_lvl[3:2]);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx done irq missing");

  property p_dre_irq;
    @(posedge clk) disable iff (!arst_n)
    (!buffer_empty_flag) |=> irq.empty_level == 2'h0;
  endproperty
  a_dre_irq: assert property (p_dre_irq) else $error("empty irq without flag");

  property p_rx_flush;
    @(posedge clk) disable iff (!arst_n)
    !rx_on |=> !frame_error_flag && !rx_overrun_flag && !parity_error_flag;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flags survive off");

  property p_tx_hold;
    @(posedge clk) disable iff (!arst_n)
    (tx_busy && !enable_ctl[SPC_EN_TX]) |=> tx_oe;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx released early");

  property p_rx_own;
    @(posedge clk) disable iff (!arst_n)
    $rose(rx_on) |=> rx_owned;
  endproperty
  a_rx_own: assert property (p_rx_own) else $error("rx pin not owned");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
    wr_bl |=> pre_cnt == 12'h000 && scl_cnt == 7'h00;
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");

  property p_txc_set;
    @(posedge clk) disable iff (!arst_n)
    (tx_finish && !tx_buf_full) |=> tx_done_flag;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("tx done flag not set");

endmodule // spc_serial_port

// ==== testbench/spc_remote_node.sv ====
`timescale 1ns/1ps
// ==========================================================
// Far-side serial node: samples device frames, sends frames back
module spc_remote_node (
  input wire logic clk, // Bench clock
  input wire logic line_in, // Device transmit level
  input wire logic line_oe, // Device drives its pin
  output logic line_out, // Level toward device receiver
  input wire logic [3:0] frame_len, // Bits after the start bit
  input wire logic [15:0] bit_clks, // Clocks per bit
  output logic [11:0] frame_bits, // Sampled bits, first in bit 0
  output logic frame_seen // One pulse per frame
);
  logic line;
  logic [11:0] acc;

  // A released pin floats to the pull-up idle level
  assign line = line_oe ? line_in : 1'b1;

  initial begin
    line_out = 1'b1;
    frame_bits = '0;
    frame_seen = 1'b0;
  end

  // ==========================================================
  // Receive: mid-bit sampling, stop bits included in the count
  always begin
    @(negedge line);
    repeat (bit_clks / 2) @(posedge clk);
    acc = '0;
    for (int i = 0; i < frame_len; i++) begin
      repeat (bit_clks) @(posedge clk);
      acc[i] = line;
    end
    frame_bits <= acc;
    frame_seen <= 1'b1;
    @(posedge clk);
    frame_seen <= 1'b0;
  end

  // ==========================================================
  // Send start bit, then bits first-bit-first, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
endmodule // spc_remote_node

// ==== testbench/serial_port_control_config_tb_top.sv ====
`timescale 1ns/1ps
module serial_port_control_config_tb_top
  import spc_pkg::*;
;
  logic clk;
  logic arst_n;
  spc_req_t req;
  logic [7:0] rdata;
  logic rx_pin;
  logic tx_out;
  logic tx_oe;
  logic rx_owned;
  logic xck_out;
  spc_irq_t irq;
  logic [3:0] frame_len;
  logic [15:0] bit_clks;
  logic [11:0] frame_bits;
  logic frame_seen;
  logic rd_seen = 1'b0;
  logic [15:0] lfsr;
  logic [7:0] rd_q[$];
  logic [11:0] fr_q[$];
  int bad_count = 0;
  int tests_run = 0;
  // Transmit cases: format, enable, baud low, baud high, clocks per bit
  logic [7:0] t_fmt[7] = '{8'h03, 8'h2b, 8'h30, 8'h07, 8'h06, 8'h21, 8'h3a};
  logic [7:0] t_en[7] = '{8'h08, 8'h08, 8'h0c, 8'h09, 8'h08, 8'h08, 8'h08};
  logic [7:0] t_bl[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h02};
  logic [7:0] t_bh[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h90, 8'h00};
  int t_per[7] = '{16, 16, 8, 32, 32, 16, 48};
  logic [7:0] rst_v[8] = '{8'h00, 8'h20, 8'h00, SPC_RST_IRQLVL, SPC_RST_ENABLE, SPC_RST_FORMAT, SPC_RST_BAUDL,
    SPC_RST_BAUDH};

  spc_serial_port spc_serial_port_inst (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .rx_pin(rx_pin),
    .tx_out(tx_out), .tx_oe(tx_oe), .rx_owned(rx_owned), .xck_out(xck_out), .irq(irq));
  spc_remote_node spc_remote_node_inst (.clk(clk), .line_in(tx_out), .line_oe(tx_oe), .line_out(rx_pin),
    .frame_len(frame_len), .bit_clks(bit_clks), .frame_bits(frame_bits), .frame_seen(frame_seen));

  // ==========================================================
  // Clock, comparison and closing
  initial begin
    clk = 1'b0;
    forever begin
      #10 clk = ~clk;
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  always @(posedge clk) begin
    if (rd_seen) begin
      check(rdata, rd_q.pop_front());
    end
    rd_seen <= req.rd;
  end

  always @(posedge clk) begin
    if (frame_seen) begin
      check(frame_bits, fr_q.pop_front());
    end
  end

  // ==========================================================
  // Bus cycles and frame helpers
  task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    bus(a, 8'h00, 1'b0);
  endtask

  // Bounded wait until every expected frame has been seen
  task automatic drain();
    for (int i = 0; i < 3000 && fr_q.size() > 0; i++) begin
      @(posedge clk);
    end
    check(12'(fr_q.size()), 12'h000);
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int nbits(input logic [7:0] fmt);
    return (fmt[2:0] == 3'h7) ? 9 : (fmt[2] ? 8 : 5 + fmt[1:0]);
  endfunction

  function automatic int flen(input logic [7:0] fmt);
    return nbits(fmt) + fmt[5] + 1 + fmt[3];
  endfunction

  // Data, parity, then stop bits; odd parity starts the sum at one
  function automatic logic [11:0] frame_of(input logic [8:0] d, input logic [7:0] fmt);
    logic [11:0] f;
    logic p;
    f = '1;
    p = fmt[4];
    for (int k = 0; k < nbits(fmt); k++) begin
      f[k] = d[k];
      p = p ^ d[k];
    end
    if (fmt[5]) begin
      f[nbits(fmt)] = p;
    end
    return f & ((12'h001 << flen(fmt)) - 12'h001);
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    req = '0;
    frame_len = 4'h0;
    bit_clks = 16'h0010;
    lfsr = 16'hdab2;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    check(tx_oe, 1'b0);
    check(irq, 6'h00);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rst_v[a]);
    end
    wr(SPC_OFF_ENABLE, 8'he0);
    rd(SPC_OFF_ENABLE, 8'h00);
    $display("Test reset values done");
    // Every width, parity and stop choice, several bit rates
    for (int c = 0; c < 7; c++) begin
      wr(SPC_OFF_FORMAT, t_fmt[c]);
      wr(SPC_OFF_BAUDH, t_bh[c]);
      wr(SPC_OFF_BAUDL, t_bl[c]);
      wr(SPC_OFF_ENABLE, t_en[c]);
      rd(SPC_OFF_FORMAT, t_fmt[c]);
      rd(SPC_OFF_BAUDH, t_bh[c]);
      check(tx_oe, 1'b1);
      frame_len <= 4'(flen(t_fmt[c]));
      bit_clks <= 16'(t_per[c]);
      lfsr = lfsr_next(lfsr);
      fr_q.push_back(frame_of({t_en[c][0], lfsr[7:0]}, t_fmt[c]));
      wr(SPC_OFF_DATA, lfsr[7:0]);
      drain();
    end
    // Let the last stop bit finish before looking at tx done
    repeat (60) @(posedge clk);
    rd(SPC_OFF_STATUS, 8'h60);
    wr(SPC_OFF_IRQLVL, 8'h0e);
    repeat (3) @(posedge clk);
    check(irq, {2'h3, 2'h2, 2'h0});
    wr(SPC_OFF_STATUS, 8'h40);
    repeat (3) @(posedge clk);
    check(irq, {2'h0, 2'h2, 2'h0});
    // Switching off with a frame still queued must not cut the frame short
    fr_q.push_back(frame_of(9'h05a, t_fmt[6]));
    wr(SPC_OFF_DATA, 8'h5a);
    wr(SPC_OFF_ENABLE, 8'h00);
    check(tx_oe, 1'b1);
    drain();
    repeat (60) @(posedge clk);
    check(tx_oe, 1'b0);
    $display("Test transmit done");
    // Receive with good and bad parity, then flush by disabling
    wr(SPC_OFF_STATUS, 8'h40);
    wr(SPC_OFF_FORMAT, 8'h23);
    wr(SPC_OFF_BAUDL, 8'h00);
    wr(SPC_OFF_ENABLE, 8'h10);
    bit_clks <= 16'h0010;
    repeat (2) @(posedge clk);
    check(rx_owned, 1'b1);
    for (int k = 0; k < 2; k++) begin
      spc_remote_node_inst.send(frame_of(9'h0a5, 8'h23) ^ (12'(k) << 8), 10);
      repeat (16) @(posedge clk);
      rd(SPC_OFF_STATUS, 8'ha0 | 8'(k << 2));
      rd(SPC_OFF_DATA, 8'ha5);
    end
    spc_remote_node_inst.send(frame_of(9'h03c, 8'h23) ^ 12'h300, 10);
    repeat (16) @(posedge clk);
    rd(SPC_OFF_STATUS, 8'hb4);
    wr(SPC_OFF_ENABLE, 8'h00);
    rd(SPC_OFF_STATUS, 8'h20);
    check(rx_owned, 1'b0);
    // Address filter: data frame dropped, address frame kept
    wr(SPC_OFF_FORMAT, 8'h07);
    wr(SPC_OFF_ENABLE, 8'h12);
    for (int k = 0; k < 2; k++) begin
      spc_remote_node_inst.send(frame_of({k[0], 8'h55}, 8'h07), 10);
      repeat (16) @(posedge clk);
      rd(SPC_OFF_STATUS, k ? 8'ha1 : 8'h20);
    end
    rd(SPC_OFF_DATA, 8'h55);
    repeat (4) @(posedge clk);
    $display("Test receive done");
    stop_test();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule // serial_port_control_config_tb_top
